// file: rtl/hdlie_pkg.sv
// Purpose: constants and types for the data link 3 interrupt enable block
// Assumes: ahb-lite slave, 32-bit data, one word per register
// Notes:   status and enable share one bit layout
// How it works
// - enable bit 6 lets a transmit start event raise the interrupt.
// - enable bit 5 lets a receive start event raise the interrupt.
// - enable bit 4 lets a transmit end event raise the interrupt.
// - enable bit 3 lets a receive end event raise the interrupt.
// - each status flag holds its event until a read of status clears it.
// - receive end is flagged on message end or buffer full, first wins.
package hdlie_pkg;
  localparam logic [7:0] ADDR_ENABLES = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam int         BIT_TX_START = 6;
  localparam int         BIT_RX_START = 5;
  localparam int         BIT_TX_END   = 4;
  localparam int         BIT_RX_END   = 3;
  localparam logic [7:0] EVENT_MASK   = 8'h78;
  localparam logic [7:0] RESET_ENABLES = 8'h00;
  localparam logic [7:0] RESET_STATUS  = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  // event strobes from the hdlc controllers
  typedef struct packed {
    logic tx_start_event;
    logic rx_start_event;
    logic tx_end_event;
    logic rx_end_msg;
    logic rx_buf_full;
  } hdlie_events_type;
endpackage

// file: rtl/hdlie_status.sv
// Purpose: sticky reset-on-read event flags
// Assumes: events are one-cycle strobes on hclk
// Notes:   a set in the clearing cycle survives
`timescale 1ns/10ps
module hdlie_status (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic [7:0] set_bits,
  input  wire logic       clr_read,
  // state
  output logic      [7:0] status
);
  logic [7:0] status_ff;
  logic [7:0] nxt_status;

  // set wins over the read clear
  assign nxt_status = (clr_read ? 8'h00 : status_ff) | set_bits;
  assign status     = status_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= hdlie_pkg::RESET_STATUS;
    end else begin
      status_ff <= nxt_status & hdlie_pkg::EVENT_MASK;
    end
  end
endmodule

// file: rtl/hdlie_top.sv
// Purpose: interrupt enable gating for data link 3 hdlc events
// Assumes: single ahb-lite master, word transfers only
// Notes:   zero wait states; unmapped reads return zero
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module hdlie_top (
  // clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [7:0]                  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic                        hready,
  input  wire logic [31:0]                 hwdata,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // hdlc controller events
  input  wire hdlie_pkg::hdlie_events_type events,
  // interrupt
  output logic                             irq
);
  logic       wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] enables_ff;
  logic [31:0] rdata_ff;
  logic       irq_ff;
  logic       ready_ff;
  logic       resp_ff;
  logic [7:0] status;
  logic [7:0] set_bits;
  logic       rx_end;
  logic       acc;
  logic       rd_stat;
  logic       rd_en;
  logic [31:0] nxt_rdata;
  logic [7:0] nxt_enables;
  logic       nxt_irq;

  // address phase decode
  assign acc     = hsel && hready &&
                   (htrans == hdlie_pkg::HTRANS_NONSEQ ||
                    htrans == hdlie_pkg::HTRANS_SEQ);
  assign rd_stat = acc && !hwrite && haddr == hdlie_pkg::ADDR_STATUS;
  assign rd_en   = acc && !hwrite && haddr == hdlie_pkg::ADDR_ENABLES;

  // receive end from message end or buffer full, whichever first
  assign rx_end = events.rx_end_msg | events.rx_buf_full;
  assign set_bits = {1'b0,
                     events.tx_start_event,
                     events.rx_start_event,
                     events.tx_end_event,
                     rx_end, 3'h0};

  hdlie_status u_status (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .set_bits (set_bits),
    .clr_read (rd_stat),
    .status   (status)
  );

  // read data sampled at address phase, shown in data phase
  assign nxt_rdata = rd_stat ? {24'h000000, status} :
                     rd_en   ? {24'h000000, enables_ff} : 32'h00000000;

  // write lands in data phase; bit 7 and low bits dropped
  assign nxt_enables = (wr_pend_ff && wr_addr_ff == hdlie_pkg::ADDR_ENABLES)
                       ? (hwdata[7:0] & hdlie_pkg::EVENT_MASK)
                       : enables_ff;

  // gate each flag with its enable
  assign nxt_irq = |(status & enables_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      enables_ff <= hdlie_pkg::RESET_ENABLES;
      rdata_ff   <= 32'h00000000;
      irq_ff     <= 1'b0;
      ready_ff   <= 1'b1;
      resp_ff    <= 1'b0;
    end else begin
      wr_pend_ff <= acc && hwrite;
      wr_addr_ff <= haddr;
      enables_ff <= nxt_enables;
      rdata_ff   <= nxt_rdata;
      irq_ff     <= nxt_irq;
      ready_ff   <= 1'b1;
      resp_ff    <= 1'b0;
    end
  end

  // outputs straight from flops; the slave never stretches or errors
  assign hrdata    = rdata_ff;
  assign hreadyout = ready_ff;
  assign hresp     = resp_ff;
  assign irq       = irq_ff;

  // checks: a strobe flags at the next edge and irq follows one edge
  // later, so each event property is the armed cycle then a raise
  sequence s_tx_start_raise;
    status[hdlie_pkg::BIT_TX_START] ##1 irq;
  endsequence

  sequence s_rx_start_raise;
    status[hdlie_pkg::BIT_RX_START] ##1 irq;
  endsequence

  sequence s_tx_end_raise;
    status[hdlie_pkg::BIT_TX_END] ##1 irq;
  endsequence

  sequence s_rx_end_raise;
    status[hdlie_pkg::BIT_RX_END] ##1 irq;
  endsequence

  property p_tx_start;
    @(posedge hclk) disable iff (!hresetn)
    (events.tx_start_event && enables_ff[hdlie_pkg::BIT_TX_START])
      |=> s_tx_start_raise;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("tx start no irq");

  property p_rx_start;
    @(posedge hclk) disable iff (!hresetn)
    (events.rx_start_event && enables_ff[hdlie_pkg::BIT_RX_START])
      |=> s_rx_start_raise;
  endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("rx start no irq");

  property p_tx_end;
    @(posedge hclk) disable iff (!hresetn)
    (events.tx_end_event && enables_ff[hdlie_pkg::BIT_TX_END])
      |=> s_tx_end_raise;
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("tx end no irq");

  property p_rx_end;
    @(posedge hclk) disable iff (!hresetn)
    (events.rx_end_msg && enables_ff[hdlie_pkg::BIT_RX_END])
      |=> s_rx_end_raise;
  endproperty
  a_rx_end: assert property (p_rx_end)
    else $error("rx end no irq");

  property p_rx_full;
    @(posedge hclk) disable iff (!hresetn)
    (events.rx_buf_full && enables_ff[hdlie_pkg::BIT_RX_END])
      |=> s_rx_end_raise;
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("buffer full no irq");

  property p_irq_masked;
    @(posedge hclk) disable iff (!hresetn)
    (enables_ff == 8'h00) |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("irq while masked");

  property p_irq_on;
    @(posedge hclk) disable iff (!hresetn)
    ((status & enables_ff) != 8'h00) |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled flag without irq");

  property p_irq_off;
    @(posedge hclk) disable iff (!hresetn)
    ((status & enables_ff) == 8'h00) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq without enabled flag");

  property p_sticky;
    @(posedge hclk) disable iff (!hresetn)
    (status[hdlie_pkg::BIT_TX_END] && !rd_stat)
      |=> status[hdlie_pkg::BIT_TX_END];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag lost");

  property p_clear;
    @(posedge hclk) disable iff (!hresetn)
    (rd_stat && set_bits == 8'h00) |=> status == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("read did not clear");

  property p_set_wins;
    @(posedge hclk) disable iff (!hresetn)
    (rd_stat && rx_end) |=> status[hdlie_pkg::BIT_RX_END];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost to read clear");

  property p_rdata;
    @(posedge hclk) disable iff (!hresetn)
    rd_stat |=> hrdata == {24'h000000, $past(status)};
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("status read not pre-clear value");

  property p_buf_full;
    @(posedge hclk) disable iff (!hresetn)
    events.rx_buf_full |=> status[hdlie_pkg::BIT_RX_END];
  endproperty
  a_buf_full: assert property (p_buf_full)
    else $error("full not flagged");

  property p_wr_en;
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_ff && wr_addr_ff == hdlie_pkg::ADDR_ENABLES)
      |=> {24'h000000, enables_ff} ==
          ($past(hwdata) & {24'h000000, hdlie_pkg::EVENT_MASK});
  endproperty
  a_wr_en: assert property (p_wr_en)
    else $error("enable write wrong");

  property p_reserved;
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |-> enables_ff[7] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("bit 7 set");
endmodule

// file: dv/tb_hdlie_top.sv
// Purpose: self-checking bench for the data link 3 interrupt enables
// Assumes: zero wait slave, hready looped back from hreadyout
// Notes:   every event is tried masked first, then enabled
`timescale 1ns/10ps
module tb_hdlie_top;
  logic                         hclk = 1'b0;
  logic                         hresetn = 1'b0;
  logic                         hsel = 1'b0;
  logic                         hwrite = 1'b0;
  logic [7:0]                   haddr = 8'h00;
  logic [1:0]                   htrans = 2'h0;
  logic [2:0]                   hsize = 3'h2;
  logic [31:0]                  hwdata = 32'h0;
  logic [31:0]                  hrdata;
  logic [31:0]                  rd;
  logic [7:0]                   exp;
  logic                         hreadyout;
  logic                         hresp;
  logic                         irq;
  hdlie_pkg::hdlie_events_type  events = '0;
  int                           fail_count = 0;
  int                           n_checks = 0;

  // 50 ns period
  always #25 hclk = ~hclk;

  hdlie_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .events(events), .irq(irq));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // bounded wait for hready; values seen are those before this edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        $display("[FAIL] %0t hready timeout", $time);
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  // one single word transfer, read data kept in rd
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= hdlie_pkg::HTRANS_NONSEQ;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t reg got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_irq(input logic e);
    n_checks++;
    if (irq !== e) begin
      fail_count++;
      $display("[FAIL] %0t irq got %b exp %b", $time, irq, e);
    end
  endtask

  // one-cycle strobe, then wait for status and irq to land
  task automatic pulse(input int i);
    events <= hdlie_pkg::hdlie_events_type'(5'h10 >> i);
    @(posedge hclk);
    events <= '0;
    repeat (2) @(posedge hclk);
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, hdlie_pkg::ADDR_ENABLES, 32'h0);
    chk(rd, 32'h0);
    chk_irq(1'b0);
    bus(1'b1, hdlie_pkg::ADDR_ENABLES, 32'hFFFFFFFF);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, hdlie_pkg::ADDR_ENABLES, 32'h0);
    chk(rd, 32'h78);
    $display("test reset_and_reserved done");
    // rx end has two causes, both land on bit 3
    for (int i = 0; i < 5; i++) begin
      exp = (i < 4) ? (8'h40 >> i) : 8'h08;
      bus(1'b1, hdlie_pkg::ADDR_ENABLES, 32'h0);
      pulse(i);
      chk_irq(1'b0);
      bus(1'b1, hdlie_pkg::ADDR_ENABLES, {24'h0, exp});
      repeat (2) @(posedge hclk);
      chk_irq(1'b1);
      bus(1'b0, hdlie_pkg::ADDR_STATUS, 32'h0);
      chk(rd, {24'h0, exp});
      bus(1'b0, hdlie_pkg::ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk_irq(1'b0);
      pulse(i);
      chk_irq(1'b1);
      bus(1'b0, hdlie_pkg::ADDR_STATUS, 32'h0);
      chk(rd, {24'h0, exp});
      $display("test event %0d done", i);
    end
    // strobe in the very cycle a status read clears: the flag survives
    events <= hdlie_pkg::hdlie_events_type'(5'h01);
    fork
      bus(1'b0, hdlie_pkg::ADDR_STATUS, 32'h0);
      begin
        @(posedge hclk);
        events <= '0;
      end
    join
    chk(rd, 32'h0);
    bus(1'b0, hdlie_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h08);
    $display("test set_wins done");
    // reset in mid-run drops the enables and a pending flag
    pulse(0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_irq(1'b0);
    bus(1'b0, hdlie_pkg::ADDR_ENABLES, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, hdlie_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test mid_reset done");
    end_of_test();
  end
endmodule
